// [psfp_fault_ctrl.sv]
// Operation
// - Fault forces stage high-Z, shutdown low
// - Non-latched faults recover automatically
// - Local errors disable pair or all
// - Bootstrap undervoltage disables own half-bridge
// - Short test only at startup
// - Detected short holds all high-Z
// - Ground step then supply step
// - Test duration scales with filter capacitance; code uses a fixed STEP_CYC cycles per step
// - Test holds shutdown low, ignores reset
// - Reset never restarts short test
// - Short test skipped in single-ended
// - Three-level warnings then thermal shutdown
// - Two-level warning then thermal shutdown
// - Thermal shutdown latched until reset
// - Supply undervoltage disables all, auto-resumes
// - Reset low forces all high-Z
// - Reset low pulldown except single-ended
// - Reset low forces shutdown high
// - Reset rise clears overload, restarts
// - Overcurrent drives ready low
// - Clip indication near clipping
// - Shutdown and warnings active-low open-drain
module psfp_fault_ctrl
  import psfp_pkg::*;
#(
  parameter int STEP_CYC = SHORT_STEP_CYC,
  parameter bit THREE_LEVEL = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic por_i,
  input wire logic [1:0] cfg_i,
  input wire logic common_uv_i,
  input wire logic [3:0] gate_uv_i,
  input wire logic [3:0] boot_uv_i,
  input wire logic [3:0] overload_i,
  input wire logic [3:0] overcurrent_i,
  input wire logic temp_low_i,
  input wire logic temp_mid_i,
  input wire logic temp_high_i,
  input wire logic short_gnd_i,
  input wire logic short_supply_i,
  input wire logic clip_near_i,
  output logic [3:0] hb_enable_o,
  output logic [3:0] hb_pulldown_o,
  output logic fault_shutdown_n_o,
  output logic fault_shutdown_n_oe_o,
  output logic thermal_warning_low_n_o,
  output logic thermal_warning_low_n_oe_o,
  output logic thermal_warning_high_n_o,
  output logic thermal_warning_high_n_oe_o,
  output logic ready_o,
  output logic clip_o
);

  // ****************************************
  // Short test
  // ****************************************
  psfp_flag_if flags ();
  logic supply_ok;

  assign supply_ok = !common_uv_i && !(|gate_uv_i);

  psfp_short_test #(
    .STEP_CYC(STEP_CYC)
  ) u_short (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .por_i(por_i),
    .supply_ok_i(supply_ok),
    .cfg_i(cfg_i),
    .short_gnd_i(short_gnd_i),
    .short_supply_i(short_supply_i),
    .flags(flags)
  );

  // ****************************************
  // Reset edge and latched faults
  // ****************************************
  logic reset_n_q;
  logic thermal_shutdown_latch_q;
  logic [3:0] overload_protection_q;
  logic reset_eff;
  logic reset_rise;

  // Reset is ignored while the short test runs
  assign reset_eff = reset_n_i || flags.short_busy;
  assign reset_rise = reset_eff && !reset_n_q;

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      reset_n_q <= 1'b1;
    end else begin
      reset_n_q <= reset_eff;
    end
  end

  // Set wins over the clearing reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      thermal_shutdown_latch_q <= 1'b0;
    end else if (temp_high_i) begin
      thermal_shutdown_latch_q <= 1'b1;
    end else if (!reset_eff) begin
      thermal_shutdown_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      overload_protection_q <= 4'h0;
    end else if (reset_rise) begin
      overload_protection_q <= overload_i;
    end else begin
      overload_protection_q <= overload_protection_q | overload_i;
    end
  end

  // ****************************************
  // Half-bridge shutdown decision
  // ****************************************
  logic [3:0] local_off;
  logic [3:0] hb_off;
  logic global_off;
  logic any_fault;

  assign global_off = thermal_shutdown_latch_q || temp_high_i || !supply_ok;
  assign local_off = psfp_group_map(overload_protection_q | overload_i | overcurrent_i, cfg_i);
  assign hb_off = local_off | boot_uv_i | {4{global_off || flags.short_busy}};
  assign any_fault = |(hb_off);

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      hb_enable_o <= 4'h0;
      hb_pulldown_o <= 4'h0;
    end else begin
      hb_enable_o <= (!reset_eff) ? 4'h0 : ~hb_off;
      hb_pulldown_o <= (!reset_eff && cfg_i != CFG_SINGLE) ? 4'hf : 4'h0;
    end
  end

  // ****************************************
  // Indications (shutdown and warnings open-drain, active low)
  // ****************************************
  logic sd_low;
  logic warn_low;
  logic warn_high;

  assign sd_low = flags.short_busy || (reset_eff && any_fault);
  assign warn_low = THREE_LEVEL ? temp_low_i : temp_mid_i;
  assign warn_high = temp_mid_i;

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      fault_shutdown_n_o <= 1'b0;
      thermal_warning_low_n_o <= 1'b1;
      thermal_warning_high_n_o <= 1'b1;
      ready_o <= 1'b0;
      clip_o <= 1'b0;
    end else begin
      fault_shutdown_n_o <= !sd_low;
      thermal_warning_low_n_o <= !warn_low;
      thermal_warning_high_n_o <= !warn_high;
      ready_o <= reset_eff && !flags.short_busy && !(|overcurrent_i) && !any_fault;
      clip_o <= clip_near_i;
    end
  end

  assign fault_shutdown_n_oe_o = !fault_shutdown_n_o;
  assign thermal_warning_low_n_oe_o = !thermal_warning_low_n_o;
  assign thermal_warning_high_n_oe_o = !thermal_warning_high_n_o;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_reset_low;
    !reset_eff;
  endsequence

  a_reset_hiz: assert property (@(posedge clk_i) disable iff (por_i)
    s_reset_low |=> (hb_enable_o == 4'h0))
    else $error("half-bridge enabled during reset");
  a_reset_sd_high: assert property (@(posedge clk_i) disable iff (por_i)
    s_reset_low |=> fault_shutdown_n_o)
    else $error("shutdown low during reset");
  a_thermal_off: assert property (@(posedge clk_i) disable iff (por_i)
    temp_high_i && reset_eff |=> !fault_shutdown_n_o && hb_enable_o == 4'h0)
    else $error("thermal shutdown not applied");
  a_thermal_latch: assert property (@(posedge clk_i) disable iff (por_i)
    thermal_shutdown_latch_q && reset_eff |=> thermal_shutdown_latch_q)
    else $error("thermal latch cleared without reset");
  a_uv_off: assert property (@(posedge clk_i) disable iff (por_i)
    !supply_ok |=> hb_enable_o == 4'h0)
    else $error("undervoltage did not disable stage");
  a_busy_sd_low: assert property (@(posedge clk_i) disable iff (por_i)
    flags.short_busy |=> !fault_shutdown_n_o)
    else $error("shutdown released during short test");
  a_oc_ready: assert property (@(posedge clk_i) disable iff (por_i)
    (|overcurrent_i) |=> !ready_o)
    else $error("ready high during overcurrent");
  a_single_nopull: assert property (@(posedge clk_i) disable iff (por_i)
    cfg_i == CFG_SINGLE |=> hb_pulldown_o == 4'h0)
    else $error("pulldown in single-ended mode");

  // ****************************************
  // Fault mapping, latches and indications
  // ****************************************
  sequence s_reset_release;
    !reset_eff ##1 reset_eff;
  endsequence

  a_reset_pulldown: assert property (@(posedge clk_i) disable iff (por_i)
    s_reset_low ##0 (cfg_i != CFG_SINGLE) |=> hb_pulldown_o == 4'hf)
    else $error("pulldown missing during reset");
  a_pair_ab: assert property (@(posedge clk_i) disable iff (por_i)
    reset_eff && cfg_i != CFG_PARALLEL && (overcurrent_i[HB_A] || overcurrent_i[HB_B])
    |=> hb_enable_o[HB_B:HB_A] == 2'h0)
    else $error("pair A and B not disabled");
  a_pair_cd: assert property (@(posedge clk_i) disable iff (por_i)
    reset_eff && cfg_i != CFG_PARALLEL && (overcurrent_i[HB_C] || overcurrent_i[HB_D])
    |=> hb_enable_o[HB_D:HB_C] == 2'h0)
    else $error("pair C and D not disabled");
  a_parallel_all: assert property (@(posedge clk_i) disable iff (por_i)
    reset_eff && cfg_i == CFG_PARALLEL && (|overcurrent_i) |=> hb_enable_o == 4'h0)
    else $error("parallel error did not disable all");
  a_boot_own: assert property (@(posedge clk_i) disable iff (por_i)
    reset_eff && !flags.short_busy && !global_off && local_off == 4'h0
    |=> hb_enable_o == ~$past(boot_uv_i))
    else $error("bootstrap undervoltage hit other half-bridges");
  a_overload_hold: assert property (@(posedge clk_i) disable iff (por_i)
    !reset_rise |=> (overload_protection_q & $past(overload_protection_q)) == $past(overload_protection_q))
    else $error("overload latch lost without reset");
  a_overload_clear: assert property (@(posedge clk_i) disable iff (por_i)
    s_reset_release ##0 (overload_i == 4'h0) |=> overload_protection_q == 4'h0)
    else $error("reset release did not clear overload");
  a_thermal_clear: assert property (@(posedge clk_i) disable iff (por_i)
    s_reset_low ##0 !temp_high_i |=> !thermal_shutdown_latch_q)
    else $error("thermal latch not cleared by reset");
  a_warn_three: assert property (@(posedge clk_i) disable iff (por_i)
    THREE_LEVEL && temp_low_i |=> !thermal_warning_low_n_o)
    else $error("first warning missing");
  a_warn_two: assert property (@(posedge clk_i) disable iff (por_i)
    !THREE_LEVEL && temp_mid_i |=> !thermal_warning_low_n_o)
    else $error("single warning missing");
  a_warn_mid: assert property (@(posedge clk_i) disable iff (por_i)
    temp_mid_i |=> !thermal_warning_high_n_o)
    else $error("second warning missing");
  a_clip_follow: assert property (@(posedge clk_i) disable iff (por_i)
    1'b1 |=> clip_o == $past(clip_near_i))
    else $error("clip indication does not follow input");

endmodule : psfp_fault_ctrl

// [psfp_pkg.sv]
package psfp_pkg;

  // ****************************************
  // Output configuration
  // ****************************************
  localparam logic [1:0] CFG_BRIDGE = 2'h0;
  localparam logic [1:0] CFG_PARALLEL = 2'h1;
  localparam logic [1:0] CFG_SINGLE = 2'h2;

  // ****************************************
  // Half-bridge bit positions (A..D)
  // ****************************************
  localparam int HB_A = 0;
  localparam int HB_B = 1;
  localparam int HB_C = 2;
  localparam int HB_D = 3;
  localparam int HB_NUM = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int SHORT_STEP_US = 1000;
  localparam int SHORT_STEP_CYC = (CLK_HZ / 1000000) * SHORT_STEP_US;
  localparam int SHORT_TEST_MS_PER_UF = 15;
  localparam int SD_TO_RESET_MS = 4;

  // ****************************************
  // Startup short test states
  // ****************************************
  typedef enum logic [3:0] {
    SST_GND = 4'h1,
    SST_SUPPLY = 4'h2,
    SST_HOLD = 4'h4,
    SST_DONE = 4'h8
  } psfp_sst_t;

  // Map a local per-half-bridge error onto the half-bridges to turn off
  function automatic logic [3:0] psfp_group_map(input logic [3:0] err, input logic [1:0] cfg);
    logic [3:0] off;
    off = 4'h0;
    if (cfg == CFG_PARALLEL) begin
      off = (|err) ? 4'hf : 4'h0;
    end else begin
      if (err[HB_A] | err[HB_B]) begin
        off = off | 4'h3;
      end
      if (err[HB_C] | err[HB_D]) begin
        off = off | 4'hc;
      end
    end
    return off;
  endfunction : psfp_group_map

endpackage : psfp_pkg

// [psfp_flag_if.sv]
interface psfp_flag_if;
  logic short_busy;
  logic short_hold;
  logic short_done;
  modport ctrl (input short_busy, input short_hold, input short_done);
  modport test (output short_busy, output short_hold, output short_done);
endinterface : psfp_flag_if

// [psfp_short_test.sv]
module psfp_short_test
  import psfp_pkg::*;
#(
  parameter int STEP_CYC = SHORT_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic por_i,
  input wire logic supply_ok_i,
  input wire logic [1:0] cfg_i,
  input wire logic short_gnd_i,
  input wire logic short_supply_i,
  psfp_flag_if.test flags
);

  // ****************************************
  // Two-step startup short test
  // ****************************************
  psfp_sst_t state_q;
  logic [31:0] cnt_q;

  // Power-on, or a detected short clearing in SST_HOLD, restarts the test; device reset does not
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      state_q <= SST_GND;
      cnt_q <= 32'h0;
    end else begin
      case (state_q)
        SST_GND: begin
          if (cfg_i == CFG_SINGLE) begin
            state_q <= SST_DONE;
          end else if (!supply_ok_i) begin
            cnt_q <= 32'h0;
          end else if (short_gnd_i) begin
            state_q <= SST_HOLD;
            cnt_q <= 32'h0;
          end else if (cnt_q >= 32'(STEP_CYC - 1)) begin
            state_q <= SST_SUPPLY;
            cnt_q <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        SST_SUPPLY: begin
          if (short_supply_i) begin
            state_q <= SST_HOLD;
            cnt_q <= 32'h0;
          end else if (cnt_q >= 32'(STEP_CYC - 1)) begin
            state_q <= SST_DONE;
            cnt_q <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        SST_HOLD: begin
          if (!short_gnd_i && !short_supply_i) begin
            state_q <= SST_GND;
          end
        end
        SST_DONE: begin
          state_q <= SST_DONE;
        end
        default: begin
          state_q <= SST_GND;
        end
      endcase
    end
  end

  assign flags.short_busy = (state_q != SST_DONE);
  assign flags.short_hold = (state_q == SST_HOLD);
  assign flags.short_done = (state_q == SST_DONE);

  a_done_sticky: assert property (@(posedge clk_i) disable iff (por_i)
    (state_q == SST_DONE) |=> (state_q == SST_DONE))
    else $error("short test left done state without power-on");
  a_gnd_first: assert property (@(posedge clk_i) disable iff (por_i)
    (state_q == SST_SUPPLY) |-> $past(state_q) inside {SST_GND, SST_SUPPLY})
    else $error("supply step not preceded by ground step");
  a_reset_keeps_done: assert property (@(posedge clk_i) disable iff (por_i)
    (state_q == SST_DONE && !reset_n_i) |=> (state_q == SST_DONE))
    else $error("device reset restarted the short test");

endmodule : psfp_short_test

// [psfp_ctrl_model.sv]
module psfp_ctrl_model
  import psfp_pkg::*;
#(
  parameter int WAIT_CYC = SD_TO_RESET_MS * (CLK_HZ / 1000)
) (
  input wire logic clk_i,
  input wire logic fault_shutdown_n_i,
  input wire logic reset_req_i,
  output logic reset_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Reset driver that honours the shutdown-to-reset gap
  // ****************************************
  int cnt_q = WAIT_CYC;
  logic sd_q = 1'b1;
  logic rst_n_q = 1'b1;
  assign reset_n_o = rst_n_q;
  always @(posedge clk_i) begin
    sd_q <= fault_shutdown_n_i;
    if (sd_q && !fault_shutdown_n_i) begin
      cnt_q <= 0;
    end else if (cnt_q < WAIT_CYC) begin
      cnt_q <= cnt_q + 1;
    end
    if (reset_req_i) begin
      rst_n_q <= 1'b0;
    end else if (cnt_q >= WAIT_CYC) begin
      rst_n_q <= 1'b1;
    end
  end
endmodule : psfp_ctrl_model

// [tb_top.sv]
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import psfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Stimulus, model and checks
  // ****************************************
  logic clk_i, por, cuv, tlo, tmid, thi, sg, ss, clipi, req, rst_n;
  logic [1:0] cfg;
  logic [3:0] guv, buv, ovl, ovc, hb, pd, m_ovl;
  logic sd, sd_oe, w1, w1oe, w2, w2oe, rdy, clip, w1s, w1s_oe;
  bit m_run, m_ote;
  int n_fail = 0;
  int check_count = 0;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    {cuv, tlo, tmid, thi, sg, ss, clipi, req} = '0;
    por = 1'b1;
    cfg = CFG_BRIDGE;
    {guv, buv, ovl, ovc, m_ovl} = '0;
  end
  psfp_ctrl_model #(.WAIT_CYC(20)) i_ctrl (.clk_i(clk_i), .fault_shutdown_n_i(sd), .reset_req_i(req),
    .reset_n_o(rst_n));
  psfp_fault_ctrl #(.STEP_CYC(4), .THREE_LEVEL(1'b1)) i_dut (.clk_i(clk_i), .reset_n_i(rst_n), .por_i(por),
    .cfg_i(cfg), .common_uv_i(cuv), .gate_uv_i(guv), .boot_uv_i(buv), .overload_i(ovl), .overcurrent_i(ovc),
    .temp_low_i(tlo), .temp_mid_i(tmid), .temp_high_i(thi), .short_gnd_i(sg), .short_supply_i(ss),
    .clip_near_i(clipi), .hb_enable_o(hb), .hb_pulldown_o(pd), .fault_shutdown_n_o(sd),
    .fault_shutdown_n_oe_o(sd_oe), .thermal_warning_low_n_o(w1), .thermal_warning_low_n_oe_o(w1oe),
    .thermal_warning_high_n_o(w2), .thermal_warning_high_n_oe_o(w2oe), .ready_o(rdy), .clip_o(clip));
  psfp_fault_ctrl #(.STEP_CYC(4), .THREE_LEVEL(1'b0)) i_dut_two (.clk_i(clk_i), .reset_n_i(rst_n), .por_i(por),
    .cfg_i(cfg), .common_uv_i(cuv), .gate_uv_i(guv), .boot_uv_i(buv), .overload_i(ovl), .overcurrent_i(ovc),
    .temp_low_i(tlo), .temp_mid_i(tmid), .temp_high_i(thi), .short_gnd_i(sg), .short_supply_i(ss),
    .clip_near_i(clipi), .hb_enable_o(), .hb_pulldown_o(), .fault_shutdown_n_o(),
    .fault_shutdown_n_oe_o(), .thermal_warning_low_n_o(w1s), .thermal_warning_low_n_oe_o(w1s_oe),
    .thermal_warning_high_n_o(), .thermal_warning_high_n_oe_o(), .ready_o(), .clip_o());
  task automatic cmp();
    logic [3:0] err, off, e;
    logic s;
    err = m_ovl | ovc;
    off = (cfg == CFG_PARALLEL) ? {4{|err}} : {{2{|err[3:2]}}, {2{|err[1:0]}}};
    e = (!rst_n || !m_run || m_ote || cuv || (|guv)) ? 4'h0 : ~(off | buv);
    s = m_run && (!rst_n || !(m_ote || cuv || (|guv) || (|err) || (|buv)));
    `CHK("hb_enable", e, hb)
    `CHK("shutdown_n", s, sd)
    `CHK("shutdown_oe", !s, sd_oe)
    `CHK("pulldown", (m_run && !rst_n && cfg != CFG_SINGLE) ? 4'hf : 4'h0, pd)
    `CHK("warn_low", {!tlo, tlo}, {w1, w1oe})
    `CHK("warn_high", {!tmid, tmid}, {w2, w2oe})
    `CHK("clip", clipi, clip)
    `CHK("ready_lvl", rst_n && s, rdy)
    `CHK("warn_single", {!tmid, tmid}, {w1s, w1s_oe})
  endtask : cmp
  task automatic st();
    repeat (4) @(posedge clk_i);
    #1;
    cmp();
  endtask : st
  task automatic wait_rst();
    int n;
    n = 0;
    while (rst_n !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_rst
  task automatic pulse();
    @(posedge clk_i);
    req <= 1'b1;
    st();
    @(posedge clk_i);
    req <= 1'b0;
    wait_rst();
    m_ote = 1'b0;
    m_ovl = 4'h0;
    st();
  endtask : pulse
  task automatic boot_up(input logic [1:0] c, input logic sh);
    int n;
    @(posedge clk_i);
    cfg <= c;
    por <= 1'b1;
    sg <= sh;
    req <= sh;
    m_run = 1'b0;
    repeat (2) @(posedge clk_i);
    por <= 1'b0;
    if (sh) begin
      st();
      @(posedge clk_i);
      req <= 1'b0;
      wait_rst();
      repeat (20) @(posedge clk_i);
      #1;
      cmp();
      @(posedge clk_i);
      sg <= 1'b0;
    end
    n = 0;
    while (sd !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("short_test_len", c != CFG_SINGLE, n >= 8)
    m_run = 1'b1;
    st();
  endtask : boot_up
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #(50 * 20000);
    n_fail++;
    complete_run();
  end
  initial begin
    int r;
    void'($urandom(32'h4194910f));
    boot_up(CFG_BRIDGE, 1'b1);
    for (int c = 2; c >= 0; c--) begin
      boot_up(c[1:0], 1'b0);
      for (int b = 0; b < 4; b++) begin
        @(posedge clk_i);
        ovc <= 4'h1 << b;
        st();
        `CHK("ready", 1'b0, rdy)
        @(posedge clk_i);
        ovc <= 4'h0;
        buv <= 4'h1 << b;
        st();
        @(posedge clk_i);
        buv <= 4'h0;
        st();
        `CHK("ready", 1'b1, rdy)
      end
      @(posedge clk_i);
      cuv <= 1'b1;
      pulse();
      @(posedge clk_i);
      cuv <= 1'b0;
      st();
    end
    @(posedge clk_i);
    {sg, ss, tlo} <= 3'h7;
    clipi <= 1'($urandom);
    st();
    @(posedge clk_i);
    guv <= 4'h1 << $urandom_range(3);
    tmid <= 1'b1;
    st();
    @(posedge clk_i);
    {guv, sg, ss} <= '0;
    thi <= 1'b1;
    m_ote = 1'b1;
    st();
    @(posedge clk_i);
    {thi, tmid, tlo} <= 3'h0;
    st();
    pulse();
    r = $urandom_range(3);
    @(posedge clk_i);
    ovl <= 4'h1 << r;
    m_ovl = 4'h1 << r;
    st();
    @(posedge clk_i);
    ovl <= 4'h0;
    st();
    pulse();
    complete_run();
  end
endmodule : tb_top
